// File: core/sfid_dev.sv
// Flash instruction decoder, device end
module sfid_dev
	import sfid_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	sfid_link_if.dev_mp      lnk,
	input  wire logic [7:0]  status_1,
	input  wire logic [7:0]  status_2,
	input  wire logic [7:0]  arr_data,
	output logic      [23:0] arr_addr,
	input  wire logic        busy,
	input  wire logic        prot_en,
	input  wire logic [23:0] prot_base,
	input  wire logic [23:0] prot_top,
	output logic             cmd_valid,
	output sfid_cmd_t        cmd_kind,
	output logic      [23:0] cmd_addr,
	output logic      [15:0] sr_data,
	output logic             sr_both,
	output logic             sr_volatile,
	output logic             prog_valid,
	output logic      [7:0]  prog_col,
	output logic      [7:0]  prog_data,
	output logic             write_latch_bit,
	output logic             power_down,
	output logic             soft_rst
);

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic is_prog(input logic [7:0] op);
		return (op == OP_PP) || (op == OP_SSPRG);
	endfunction

	function automatic logic is_rdsr(input logic [7:0] op);
		return (op == OP_RDSR1) || (op == OP_RDSR2);
	endfunction

	function automatic logic hits(input logic [23:0] a, input logic [23:0] m);
		logic [23:0] s;
		logic [23:0] e;
		s = a & ~m;
		e = a | m;
		return prot_en && !((e < prot_base) || (s > prot_top));
	endfunction

	// Next byte to shift out; nb is the index of that byte
	function automatic logic [7:0] tx_pick(input logic [7:0] op, input logic [NB_W-1:0] nb);
		logic [7:0] r;
		r = 8'h00;
		unique case (op)
			OP_RDSR1: r = status_1;
			OP_RDSR2: r = status_2;
			OP_READ:  r = (nb >= NB_ADDR) ? arr_data : 8'h00;
			OP_FREAD,
			OP_SSRD:  r = (nb >= NB_DUMMY1) ? arr_data : 8'h00;
			OP_RPDID: r = (nb >= NB_ADDR) ? ID_DEV : 8'h00;
			OP_MFDID: r = (nb >= NB_ADDR) ? (nb[0] ? ID_DEV : ID_MAKER) : 8'h00;
			OP_JEDID: r = (nb == NB_OP) ? ID_MAKER : (nb == NB_B2) ? ID_MTYPE :
				(nb == NB_B3) ? ID_CAPAC : 8'h00;
			OP_UNQID: r = (nb >= NB_DUMMY1 && nb < NB_UID_END) ?
				ID_UNIQ[8*(NB_UID_END-13'h1-nb) +: 8] : 8'h00;
			default:  r = 8'h00;
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// Link domain: frame capture
	// ----------------------------------------
	logic              started_q;
	logic [CNT_W-1:0]  bits_q;
	logic [CNT_W-1:0]  bits_d;
	logic [7:0]        sh_q;
	logic [7:0]        byte_v;
	logic [7:0]        op_q;
	logic [7:0]        tx_nxt;
	logic [23:0]       addr_q;
	logic [15:0]       sr_q;
	logic [7:0]        col_q;
	logic [7:0]        pb_col_q;
	logic [7:0]        pb_data_q;
	logic              pb_tgl_q;
	logic              fr_tgl_q;
	logic [23:0]       rd_addr_q;
	logic [7:0]        tx_q;
	logic              so_q;
	logic [1:0]        lsync_m_q;
	logic [1:0]        lsync_s_q;
	logic              quiet;
	logic              byte_done;
	logic [NB_W-1:0]   nb;
	logic              arr_rd;

	always_comb begin
		bits_d = started_q ? ((bits_q == '1) ? bits_q : bits_q + 16'h1) : 16'h1;
	end
	assign byte_v    = {sh_q[6:0], lnk.serial_in};
	assign byte_done = (bits_d[2:0] == 3'h0);
	assign nb        = bits_d[CNT_W-1:3];
	assign quiet     = (lsync_s_q[1] && op_q != OP_RPDID) || (lsync_s_q[0] && !is_rdsr(op_q));
	assign arr_rd    = ((op_q == OP_READ) && nb > NB_ADDR) ||
		((op_q == OP_FREAD || op_q == OP_SSRD) && nb > NB_DUMMY1);
	// Byte picked at the fall that starts it, so a plain read has its address by then
	assign tx_nxt    = quiet ? 8'h00 :
		tx_pick(op_q, bits_q[CNT_W-1:3]);

	// Frame start marker, cleared whenever select is high
	always_ff @(posedge lnk.sclk or posedge lnk.sel_n) begin
		if (lnk.sel_n)
			started_q <= 1'b0;
		else
			started_q <= 1'b1;
	end

	// Bit count and shift-in
	always_ff @(posedge lnk.sclk or negedge rst_b) begin
		if (!rst_b) begin
			bits_q   <= '0;
			sh_q     <= 8'h00;
			fr_tgl_q <= 1'b0;
		end else begin
			bits_q <= bits_d;
			sh_q   <= byte_v;
			if (!started_q)
				fr_tgl_q <= ~fr_tgl_q;
		end
	end

	// Opcode, address and status bytes
	always_ff @(posedge lnk.sclk or negedge rst_b) begin
		if (!rst_b) begin
			op_q   <= 8'h00;
			addr_q <= 24'h0;
			sr_q   <= 16'h0;
		end else if (byte_done) begin
			if (nb == NB_OP)
				op_q <= byte_v;
			if (nb >= NB_B2 && nb <= NB_ADDR)
				addr_q <= {addr_q[15:0], byte_v};
			if (nb == NB_B2 && op_q == OP_WRSR2)
				sr_q[15:8] <= byte_v;
			else if (nb == NB_B2)
				sr_q[7:0] <= byte_v;
			if (nb == NB_B3)
				sr_q[15:8] <= byte_v;
		end
	end

	// Program data hand-off, column wraps inside the page
	always_ff @(posedge lnk.sclk or negedge rst_b) begin
		if (!rst_b) begin
			col_q     <= 8'h00;
			pb_col_q  <= 8'h00;
			pb_data_q <= 8'h00;
			pb_tgl_q  <= 1'b0;
		end else if (byte_done && is_prog(op_q)) begin
			if (nb == NB_ADDR)
				col_q <= byte_v;
			if (nb > NB_ADDR) begin
				pb_data_q <= byte_v;
				pb_col_q  <= col_q;
				col_q     <= col_q + 8'h1;
				pb_tgl_q  <= ~pb_tgl_q;
			end
		end
	end

	// Read address, advanced after each array byte sent
	always_ff @(posedge lnk.sclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_addr_q <= 24'h0;
		end else if (byte_done) begin
			if (nb == NB_ADDR)
				rd_addr_q <= {addr_q[15:0], byte_v};
			else if (arr_rd && !quiet)
				rd_addr_q <= rd_addr_q + 24'h1;
		end
	end

	// Output shifts on the falling edge, MSB first
	always_ff @(negedge lnk.sclk or posedge lnk.sel_n) begin
		if (lnk.sel_n) begin
			tx_q <= 8'h00;
			so_q <= 1'b0;
		end else if (bits_q[2:0] == 3'h0) begin
			tx_q <= tx_nxt;
			so_q <= tx_nxt[7];
		end else begin
			so_q <= tx_q[~bits_q[2:0]];
		end
	end

	// Busy and power-down levels into the link domain
	always_ff @(posedge lnk.sclk or negedge rst_b) begin
		if (!rst_b) begin
			lsync_m_q <= 2'b00;
			lsync_s_q <= 2'b00;
		end else begin
			lsync_m_q <= {power_down, busy};
			lsync_s_q <= lsync_m_q;
		end
	end

	assign lnk.serial_out = so_q;
	assign arr_addr       = rd_addr_q;

	// ----------------------------------------
	// Reference domain: frame end and commit
	// ----------------------------------------
	logic [2:0]      sel_q;
	logic [2:0]      pbt_q;
	logic [1:0]      frt_q;
	logic            fr_seen_q;
	logic            busy_h_q;
	logic            arm_q;
	logic            vol_q;
	logic            fr_end;
	logic            aligned;
	logic [NB_W-1:0] fnb;
	logic            wr_ok;
	logic            wr_ena;

	assign fr_end  = sel_q[1] && !sel_q[2] && (frt_q[1] != fr_seen_q);
	assign aligned = (bits_q[2:0] == 3'h0);
	assign fnb     = bits_q[CNT_W-1:3];
	assign wr_ok   = fr_end && aligned && !busy && !power_down;
	assign wr_ena  = wr_ok && write_latch_bit;

	// Select, frame and data toggles cross by two flops
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_q     <= 3'b111;
			pbt_q     <= 3'b000;
			frt_q     <= 2'b00;
			fr_seen_q <= 1'b0;
			busy_h_q  <= 1'b0;
		end else begin
			sel_q    <= {sel_q[1:0], lnk.sel_n};
			pbt_q    <= {pbt_q[1:0], pb_tgl_q};
			frt_q    <= {frt_q[0], fr_tgl_q};
			busy_h_q <= busy;
			if (fr_end)
				fr_seen_q <= frt_q[1];
		end
	end

	// Program bytes to the machinery
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prog_valid <= 1'b0;
			prog_col   <= 8'h00;
			prog_data  <= 8'h00;
		end else begin
			prog_valid <= pbt_q[1] ^ pbt_q[2];
			if (pbt_q[1] ^ pbt_q[2]) begin
				prog_col  <= pb_col_q;
				prog_data <= pb_data_q;
			end
		end
	end

	// Command issue
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_valid   <= 1'b0;
			cmd_kind    <= CMD_PROG;
			cmd_addr    <= 24'h0;
			sr_data     <= 16'h0;
			sr_both     <= 1'b0;
			sr_volatile <= 1'b0;
		end else begin
			cmd_valid <= 1'b0;
			cmd_addr  <= addr_q;
			unique case (op_q)
				OP_PP: if (wr_ena && fnb > NB_ADDR && !hits(addr_q, 24'h0)) begin
					cmd_valid <= 1'b1;
					cmd_kind  <= CMD_PROG;
				end
				OP_SSPRG: if (wr_ena && fnb > NB_ADDR) begin
					cmd_valid <= 1'b1;
					cmd_kind  <= CMD_SEC_PROG;
				end
				OP_SE4K: if (wr_ena && fnb == NB_ADDR && !hits(addr_q, MASK_4K)) begin
					cmd_valid <= 1'b1;
					cmd_kind  <= CMD_ERASE_4K;
				end
				OP_BE32K: if (wr_ena && fnb == NB_ADDR && !hits(addr_q, MASK_32K)) begin
					cmd_valid <= 1'b1;
					cmd_kind  <= CMD_ERASE_32K;
				end
				OP_BE64K: if (wr_ena && fnb == NB_ADDR && !hits(addr_q, MASK_64K)) begin
					cmd_valid <= 1'b1;
					cmd_kind  <= CMD_ERASE_64K;
				end
				OP_CE_A,
				OP_CE_B: if (wr_ena && fnb == NB_OP && !hits(addr_q, MASK_CHIP)) begin
					cmd_valid <= 1'b1;
					cmd_kind  <= CMD_ERASE_CHIP;
				end
				OP_SSERA: if (wr_ena && fnb == NB_ADDR) begin
					cmd_valid <= 1'b1;
					cmd_kind  <= CMD_SEC_ERASE;
				end
				OP_WRSR1,
				OP_WRSR2: if (wr_ok && (write_latch_bit || vol_q) &&
					(fnb == NB_B2 || (fnb == NB_B3 && op_q == OP_WRSR1))) begin
					cmd_valid   <= 1'b1;
					cmd_kind    <= CMD_SR_WRITE;
					sr_data     <= sr_q;
					sr_both     <= (fnb == NB_B3);
					sr_volatile <= vol_q;
				end
				default: cmd_valid <= 1'b0;
			endcase
		end
	end

	// Write latch, volatile enable, power-down and reset sequence
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			write_latch_bit <= 1'b0;
			vol_q           <= 1'b0;
			power_down      <= 1'b0;
			arm_q           <= 1'b0;
			soft_rst        <= 1'b0;
		end else begin
			soft_rst <= 1'b0;
			if (busy_h_q && !busy)
				write_latch_bit <= 1'b0;
			if (fr_end)
				arm_q <= wr_ok && fnb == NB_OP && op_q == OP_RSTEN;
			if (wr_ok && fnb == NB_OP) begin
				if (op_q == OP_WRDI)
					write_latch_bit <= 1'b0;
				if (op_q == OP_WREN)
					write_latch_bit <= 1'b1;
				if (op_q == OP_VSRWE)
					vol_q <= 1'b1;
				if (op_q == OP_PDN)
					power_down <= 1'b1;
				if (op_q == OP_RST && arm_q) begin
					soft_rst        <= 1'b1;
					write_latch_bit <= 1'b0;
					vol_q           <= 1'b0;
				end
			end
			if (wr_ok && (op_q == OP_WRSR1 || op_q == OP_WRSR2))
				vol_q <= 1'b0;
			if (fr_end && !busy && op_q == OP_RPDID && fnb >= NB_OP)
				power_down <= 1'b0;
		end
	end

endmodule

// File: core/sfid_host.sv
// Serial flash host controller, link end that makes the clock
module sfid_host
	import sfid_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	sfid_link_if.host_mp     lnk,
	input  wire logic        frm_go,
	input  wire logic [15:0] frm_bits,
	output logic             frm_ready,
	input  wire logic [7:0]  tx_byte,
	output logic             tx_take,
	output logic      [7:0]  rx_byte,
	output logic             rx_valid
);

	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} sfid_hst_t;

	sfid_hst_t   st_q;
	logic [3:0]  cnt_q;
	logic [15:0] left_q;
	logic [2:0]  bitn_q;
	logic [7:0]  sh_q;
	logic [7:0]  rsh_q;
	logic        sel_n_q;
	logic        sclk_q;
	logic        sdo_q;
	logic [1:0]  so_q;
	logic        tick;
	logic        enter_low;

	assign tick      = (cnt_q == 4'h0);
	assign enter_low = tick && ((st_q == H_SETUP) || (st_q == H_HIGH && left_q != 16'h0));

	// ----------------------------------------
	// Frame sequencing and clock divider
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q      <= H_IDLE;
			cnt_q     <= 4'h0;
			left_q    <= 16'h0;
			sel_n_q   <= 1'b1;
			sclk_q    <= 1'b0;
			frm_ready <= 1'b0;
		end else begin
			cnt_q <= tick ? SCLK_HALF_CYC - 4'h1 : cnt_q - 4'h1;
			unique case (st_q)
				H_IDLE: begin
					frm_ready <= 1'b1;
					if (frm_go && frm_ready && frm_bits != 16'h0) begin
						st_q      <= H_SETUP;
						sel_n_q   <= 1'b0;
						left_q    <= frm_bits;
						frm_ready <= 1'b0;
						cnt_q     <= SCLK_HALF_CYC - 4'h1;
					end
				end
				H_SETUP: if (tick)
					st_q <= H_LOW;
				H_LOW: if (tick) begin
					sclk_q <= 1'b1;
					left_q <= left_q - 16'h1;
					st_q   <= H_HIGH;
				end
				H_HIGH: if (tick) begin
					sclk_q <= 1'b0;
					st_q   <= (left_q == 16'h0) ? H_HOLD : H_LOW;
				end
				H_HOLD: if (tick) begin
					sel_n_q <= 1'b1;
					st_q    <= H_GAP;
					cnt_q   <= CS_HIGH_CYC - 4'h1;
				end
				H_GAP: if (tick)
					st_q <= H_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Outgoing bits, MSB first
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sh_q    <= 8'h00;
			sdo_q   <= 1'b0;
			bitn_q  <= 3'h0;
			tx_take <= 1'b0;
		end else begin
			tx_take <= 1'b0;
			if (st_q == H_IDLE)
				bitn_q <= 3'h0;
			if (enter_low) begin
				bitn_q <= bitn_q + 3'h1;
				if (bitn_q == 3'h0) begin
					sh_q    <= tx_byte;
					sdo_q   <= tx_byte[7];
					tx_take <= 1'b1;
				end else begin
					sh_q  <= {sh_q[6:0], 1'b0};
					sdo_q <= sh_q[6];
				end
			end
		end
	end

	// ----------------------------------------
	// Incoming bits, taken at the rising edge
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			so_q     <= 2'b00;
			rsh_q    <= 8'h00;
			rx_byte  <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			so_q     <= {so_q[0], lnk.serial_out};
			rx_valid <= 1'b0;
			if (st_q == H_LOW && tick) begin
				rsh_q <= {rsh_q[6:0], so_q[1]};
				if (bitn_q == 3'h0) begin
					rx_byte  <= {rsh_q[6:0], so_q[1]};
					rx_valid <= 1'b1;
				end
			end
		end
	end

	assign lnk.sel_n     = sel_n_q;
	assign lnk.sclk      = sclk_q;
	assign lnk.serial_in = sdo_q;

endmodule

// File: pkg/sfid_link_if.sv
// Serial link between host controller and flash decoder
interface sfid_link_if;
	logic sel_n;
	logic sclk;
	logic serial_in;
	logic serial_out;

	modport dev_mp (
		input  sel_n,
		input  sclk,
		input  serial_in,
		output serial_out
	);

	modport host_mp (
		output sel_n,
		output sclk,
		output serial_in,
		input  serial_out
	);
endinterface

// File: pkg/sfid_pkg.sv
// Shared constants and types of the serial flash instruction decoder
package sfid_pkg;

	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_WREN  = 8'h06;
	localparam logic [7:0] OP_VSRWE = 8'h50;
	localparam logic [7:0] OP_WRDI  = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_WRSR1 = 8'h01;
	localparam logic [7:0] OP_WRSR2 = 8'h31;
	localparam logic [7:0] OP_PP    = 8'h02;
	localparam logic [7:0] OP_SE4K  = 8'h20;
	localparam logic [7:0] OP_BE32K = 8'h52;
	localparam logic [7:0] OP_BE64K = 8'hd8;
	localparam logic [7:0] OP_CE_A  = 8'hc7;
	localparam logic [7:0] OP_CE_B  = 8'h60;
	localparam logic [7:0] OP_PDN   = 8'hb9;
	localparam logic [7:0] OP_READ  = 8'h03;
	localparam logic [7:0] OP_FREAD = 8'h0b;
	localparam logic [7:0] OP_RPDID = 8'hab;
	localparam logic [7:0] OP_MFDID = 8'h90;
	localparam logic [7:0] OP_JEDID = 8'h9f;
	localparam logic [7:0] OP_UNQID = 8'h4b;
	localparam logic [7:0] OP_SSERA = 8'h44;
	localparam logic [7:0] OP_SSPRG = 8'h42;
	localparam logic [7:0] OP_SSRD  = 8'h48;
	localparam logic [7:0] OP_RSTEN = 8'h66;
	localparam logic [7:0] OP_RST   = 8'h99;

	// ----------------------------------------
	// Identity values (arbitrary values)
	// ----------------------------------------
	localparam logic [7:0]  ID_MAKER = 8'h5a;
	localparam logic [7:0]  ID_MTYPE = 8'h3c;
	localparam logic [7:0]  ID_CAPAC = 8'h4e;
	localparam logic [7:0]  ID_DEV   = 8'h33;
	localparam logic [63:0] ID_UNIQ  = 64'h0123_4567_89ab_cdef;

	// ----------------------------------------
	// Frame layout, counted in completed bytes
	// ----------------------------------------
	localparam int          CNT_W      = 16;
	localparam int          NB_W       = 13;
	localparam logic [NB_W-1:0] NB_OP      = 13'h1;
	localparam logic [NB_W-1:0] NB_B2      = 13'h2;
	localparam logic [NB_W-1:0] NB_B3      = 13'h3;
	localparam logic [NB_W-1:0] NB_ADDR    = 13'h4;
	localparam logic [NB_W-1:0] NB_DUMMY1  = 13'h5;
	localparam logic [NB_W-1:0] NB_UID_END = 13'hd;

	// ----------------------------------------
	// Erase region masks
	// ----------------------------------------
	localparam logic [23:0] MASK_4K   = 24'h000fff;
	localparam logic [23:0] MASK_32K  = 24'h007fff;
	localparam logic [23:0] MASK_64K  = 24'h00ffff;
	localparam logic [23:0] MASK_CHIP = 24'hffffff;

	// ----------------------------------------
	// Host timing in reference clock cycles
	// ----------------------------------------
	localparam logic [3:0] SCLK_HALF_CYC = 4'h4;
	localparam logic [3:0] CS_HIGH_CYC   = 4'h8;

	typedef enum logic [2:0] {
		CMD_PROG,
		CMD_SEC_PROG,
		CMD_ERASE_4K,
		CMD_ERASE_32K,
		CMD_ERASE_64K,
		CMD_ERASE_CHIP,
		CMD_SEC_ERASE,
		CMD_SR_WRITE
	} sfid_cmd_t;

endpackage

// File: test/sfid_link_assertions.sv
// Checker of the serial link between host and device ends
module sfid_link_chk
	import sfid_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic serial_in,
	input wire logic serial_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Link clock phases
	// ----------------------------------------
	sequence s_high;
		sclk [*4];
	endsequence
	sequence s_low;
		!sclk [*4];
	endsequence

	property p_clk_idle;
		sel_n |-> !sclk;
	endproperty
	property p_lead;
		$fell(sel_n) |-> !sclk [*8];
	endproperty
	property p_half;
		$rose(sclk) |-> s_high ##1 s_low;
	endproperty
	property p_din;
		sclk && $past(sclk) |-> $stable(serial_in);
	endproperty
	property p_gap;
		$rose(sel_n) |-> sel_n [*8];
	endproperty
	property p_end;
		$rose(sel_n) |-> !$past(sclk) && !$past(sclk, 3);
	endproperty
	property p_dout_idle;
		sel_n |-> !serial_out;
	endproperty
	property p_dout_edge;
		$changed(serial_out) |-> $fell(sclk) || $rose(sel_n);
	endproperty

	a_clk_idle: assert property (p_clk_idle)
		else $error("link clock moved while deselected");
	a_lead: assert property (p_lead)
		else $error("link clock too early after select");
	a_half: assert property (p_half)
		else $error("link clock half period wrong");
	a_din: assert property (p_din)
		else $error("serial input moved while clock high");
	a_gap: assert property (p_gap)
		else $error("deselect gap too short");
	a_end: assert property (p_end)
		else $error("frame ended with clock high");
	a_dout_idle: assert property (p_dout_idle)
		else $error("serial output driven while deselected");
	a_dout_edge: assert property (p_dout_edge)
		else $error("serial output moved off the falling edge");
endmodule

// File: test/testbench.sv
// Testbench joining host and device ends over the link
module testbench
	import sfid_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk, rst_b, frm_go, frm_ready, tx_take, rx_valid, busy, prot_en;
	logic cmd_valid, sr_both, sr_volatile, prog_valid, write_latch_bit, power_down, soft_rst;
	logic [15:0] frm_bits, sr_data, c0, c1;
	logic [7:0] tx_byte, rx_byte, status_1, status_2, arr_data, prog_col, prog_data;
	logic [23:0] arr_addr, prot_base, prot_top, cmd_addr, l_addr;
	logic [7:0] rx [0:15];
	sfid_cmd_t cmd_kind, l_kind;
	int miscompares, check_count;
	int n_cmd = 0;
	int n_prog = 0;
	int n_rst = 0;

	sfid_link_if lnk();
	sfid_host i_sfid_host(.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk.host_mp),
		.frm_go(frm_go), .frm_bits(frm_bits), .frm_ready(frm_ready), .tx_byte(tx_byte),
		.tx_take(tx_take), .rx_byte(rx_byte), .rx_valid(rx_valid));
	sfid_dev i_sfid_dev(.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk.dev_mp),
		.status_1(status_1), .status_2(status_2), .arr_data(arr_data), .arr_addr(arr_addr),
		.busy(busy), .prot_en(prot_en), .prot_base(prot_base), .prot_top(prot_top),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .sr_data(sr_data),
		.sr_both(sr_both), .sr_volatile(sr_volatile), .prog_valid(prog_valid),
		.prog_col(prog_col), .prog_data(prog_data), .write_latch_bit(write_latch_bit),
		.power_down(power_down), .soft_rst(soft_rst));
	sfid_link_chk u_chk(.ref_clk(ref_clk), .rst_b(rst_b), .sel_n(lnk.sel_n),
		.sclk(lnk.sclk), .serial_in(lnk.serial_in), .serial_out(lnk.serial_out));

	assign arr_data = arr_addr[7:0] + 8'h11;

	// ----------------------------------------
	// Device output monitor
	// ----------------------------------------
	always @(negedge ref_clk) begin
		if (cmd_valid === 1'b1) begin
			n_cmd++;
			l_kind = cmd_kind;
			l_addr = cmd_addr;
		end
		if (prog_valid === 1'b1) begin
			if (n_prog == 0)
				c0 = {prog_col, prog_data};
			c1 = {prog_col, prog_data};
			n_prog++;
		end
		if (soft_rst === 1'b1)
			n_rst++;
	end

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task conclude;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	task frame(input int nbits, input logic [63:0] hdr);
		int k, r, n;
		k = 0;
		r = 0;
		n = 0;
		n_cmd = 0;
		n_prog = 0;
		@(negedge ref_clk);
		tx_byte = hdr[63:56];
		frm_bits = nbits[15:0];
		frm_go = 1'b1;
		@(negedge ref_clk);
		frm_go = 1'b0;
		@(negedge ref_clk);
		while (frm_ready !== 1'b1 && n < 9000) begin
			if (tx_take === 1'b1) begin
				k++;
				tx_byte = (k < 8) ? hdr[63 - 8*k -: 8] : 8'h00;
			end
			if (rx_valid === 1'b1 && r < 16) begin
				rx[r] = rx_byte;
				r++;
			end
			n++;
			@(negedge ref_clk);
		end
		if (n == 9000) begin
			miscompares++;
			conclude();
		end
		repeat (3) @(negedge ref_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reads;
		logic [7:0] ops [0:2] = '{OP_READ, OP_FREAD, OP_SSRD};
		int ds [0:2] = '{4, 5, 5};
		frame(32, {OP_JEDID, 56'h0});
		chk({rx[1], rx[2], rx[3]}, {ID_MAKER, ID_MTYPE, ID_CAPAC});
		frame(48, {OP_MFDID, 56'h0});
		chk({rx[4], rx[5]}, {ID_MAKER, ID_DEV});
		frame(104, {OP_UNQID, 56'h0});
		chk({rx[5], rx[6], rx[7], rx[8], rx[9], rx[10], rx[11], rx[12]}, ID_UNIQ);
		for (int i = 0; i < 3; i++) begin
			frame(8 * (ds[i] + 2), {ops[i], 24'h000010, 32'h0});
			chk({rx[ds[i]], rx[ds[i] + 1]}, 16'h2122);
		end
		frame(37, {OP_READ, 56'h0});
		frame(16, {OP_RDSR1, 56'h0});
		chk(rx[1], status_1);
		frame(16, {OP_RDSR2, 56'h0});
		chk(rx[1], status_2);
		$display("reads done");
	endtask

	task t_writes;
		logic [7:0] ops [0:9] = '{OP_SE4K, OP_BE32K, OP_BE64K, OP_SSERA, OP_CE_A, OP_CE_B,
			OP_SSPRG, OP_WRSR1, OP_WRSR2, OP_WRSR1};
		sfid_cmd_t kd [0:9] = '{CMD_ERASE_4K, CMD_ERASE_32K, CMD_ERASE_64K, CMD_SEC_ERASE,
			CMD_ERASE_CHIP, CMD_ERASE_CHIP, CMD_SEC_PROG, CMD_SR_WRITE, CMD_SR_WRITE,
			CMD_SR_WRITE};
		int nb [0:9] = '{32, 32, 32, 32, 8, 8, 40, 16, 16, 24};
		for (int i = 0; i < 10; i++) begin
			frame(8, {OP_WREN, 56'h0});
			chk(write_latch_bit, 1'b1);
			frame(nb[i], {ops[i], 24'h012345, 32'h0});
			chk(n_cmd, 1);
			chk(l_kind, kd[i]);
		end
		chk({sr_both, sr_data}, {1'b1, 16'h2301});
		frame(8, {OP_WREN, 56'h0});
		frame(48, {OP_PP, 24'h0012ff, 8'h5a, 8'h6b, 16'h0});
		chk({n_cmd, n_prog}, {32'd1, 32'd2});
		chk({l_kind, l_addr}, {CMD_PROG, 24'h0012ff});
		chk({c0, c1}, 32'hff5a_006b);
		$display("writes done");
	endtask

	task t_refuse;
		frame(8, {OP_WRDI, 56'h0});
		chk(write_latch_bit, 1'b0);
		frame(32, {OP_SE4K, 56'h0});
		chk(n_cmd, 0);
		frame(8, {OP_WREN, 56'h0});
		frame(33, {OP_SE4K, 56'h0});
		chk(n_cmd, 0);
		prot_en = 1'b1;
		prot_base = 24'h010000;
		prot_top = 24'h01ffff;
		frame(32, {OP_SE4K, 24'h012345, 32'h0});
		chk(n_cmd, 0);
		prot_en = 1'b0;
		busy = 1'b1;
		frame(32, {OP_SE4K, 56'h0});
		chk(n_cmd, 0);
		frame(32, {OP_JEDID, 56'h0});
		chk(rx[1], 8'h00);
		frame(16, {OP_RDSR1, 56'h0});
		chk(rx[1], status_1);
		busy = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk(write_latch_bit, 1'b0);
		frame(8, {OP_VSRWE, 56'h0});
		chk(write_latch_bit, 1'b0);
		frame(16, {OP_WRSR1, 8'h5a, 48'h0});
		chk({n_cmd, sr_volatile}, {32'd1, 1'b1});
		$display("refusals done");
	endtask

	task t_power;
		frame(8, {OP_PDN, 56'h0});
		chk(power_down, 1'b1);
		frame(16, {OP_RDSR1, 56'h0});
		chk(rx[1], 8'h00);
		frame(40, {OP_RPDID, 56'h0});
		chk({power_down, rx[4]}, {1'b0, ID_DEV});
		n_rst = 0;
		frame(8, {OP_RST, 56'h0});
		chk(n_rst, 0);
		frame(8, {OP_RSTEN, 56'h0});
		frame(8, {OP_RST, 56'h0});
		chk(n_rst, 1);
		$display("power and reset done");
	endtask

	initial begin
		rst_b = 1'b0;
		frm_go = 1'b0;
		frm_bits = 16'h0;
		tx_byte = 8'h00;
		busy = 1'b0;
		prot_en = 1'b0;
		prot_base = 24'h0;
		prot_top = 24'h0;
		status_1 = 8'ha5;
		status_2 = 8'h3c;
		miscompares = 0;
		check_count = 0;
		repeat (5) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge ref_clk);
		t_reads();
		t_writes();
		t_refuse();
		t_power();
		conclude();
	end
endmodule
